/* File: rtl/eeprom_host_pkg.sv */
// Constants, timing counts and state type of the parallel EEPROM host controller
// Summary of operation
// RL1: Device array is 8192 bytes, 13 address bits
// RL2: Read data valid with select, gate low
// RL3: Device floats data when select or gate high
// RL4: Host writes by pulsing write strobe low
// RL5: Address latched on strobe falling edge
// RL6: Data latched on strobe rising edge
// RL7: Buses free once write data latched
// RL8: Device goes busy, self-times clear and program
// RL9: Write ends within 1 ms or 200 us
// RL10: Reads during write cycle are status polls
// RL11: Ready/busy pulled low during write cycle
// RL12: Reduced-pin variant lacks ready/busy, poll instead
// RL13: Poll read returns inverted bit 7
// RL14: True byte returned once write completes
// RL15: Host waits for write end before access
// RL16: Writes blocked while supply is low
// RL17: Writes blocked 5 ms after supply good
// RL18: No write with gate low or strobes high
// RL19: Chip clear: 12 V gate, 10 ms strobe
// RL20: 12 V on id select reaches id area
// RL21: High-voltage and supply sense are digital signals
package eeprom_host_pkg;

	// ***************************************************************
	// Geometry
	// ***************************************************************
	localparam int          ADDR_W    = 13;
	localparam int          DATA_W    = 8;
	localparam int          MEM_BYTES = 8192;
	localparam logic [12:0] ID_BASE   = 13'h1FE0;
	localparam logic [12:0] ID_TOP    = 13'h1FFF;
	localparam logic [7:0]  ID_HIGH   = 8'hFF;
	localparam int          ID_LOW_W  = 5;
	localparam int          SYNC_W    = 10;
	localparam int          SYNC_STG  = 2;

	// ***************************************************************
	// Device times, and derived cycle counts
	// ***************************************************************
	localparam int CLK_PERIOD_PS = 4000;
	localparam int T_ACC_NS      = 120;
	localparam int T_AS_NS       = 10;
	localparam int T_WP_NS       = 100;
	localparam int T_DH_NS       = 10;
	localparam int T_DB_NS       = 50;
	localparam int T_CLR_SH_NS   = 1000;
	localparam int T_WC_STD_MS   = 1;
	localparam int T_WC_FAST_US  = 200;
	localparam int T_POR_MS      = 5;
	localparam int T_CLR_MS      = 10;

	localparam int CLK_PERIOD_NS = CLK_PERIOD_PS / 1000;
	localparam int ACC_CYC    = (T_ACC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + SYNC_STG + 1;
	localparam int AS_CYC     = (T_AS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int WP_CYC     = (T_WP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int DH_CYC     = (T_DH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int DB_CYC     = (T_DB_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + SYNC_STG;
	localparam int CLR_SH_CYC = (T_CLR_SH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int GAP_CYC    = 2;
	localparam int WC_STD_CYC  = (T_WC_STD_MS * 1000000) / CLK_PERIOD_NS;
	localparam int WC_FAST_CYC = (T_WC_FAST_US * 1000) / CLK_PERIOD_NS;
	localparam int POR_CYC     = (T_POR_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CLR_CYC     = (T_CLR_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam int PH_W = 8;
	localparam int LT_W = 22;

	// ***************************************************************
	// Commands and states
	// ***************************************************************
	localparam logic [1:0] OP_READ  = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_CLEAR = 2'h2;

	typedef enum logic [3:0] {
		ST_PWR,
		ST_IDLE,
		ST_RD,
		ST_WR_SET,
		ST_WR_PULSE,
		ST_WR_HOLD,
		ST_POLL_GAP,
		ST_POLL,
		ST_CLR_SET,
		ST_CLR_PULSE,
		ST_CLR_HOLD
	} state_t;

endpackage

/* File: rtl/pin_sync.sv */
// Two-stage synchroniser for the pins that arrive from the memory device
`timescale 1ns/1ps
module pin_sync (
	input  wire logic                                ref_clk,
	input  wire logic                                resetn,
	input  wire logic                                clk_en,
	input  wire logic [eeprom_host_pkg::SYNC_W-1:0] d,
	output logic      [eeprom_host_pkg::SYNC_W-1:0] q
);

	logic [eeprom_host_pkg::SYNC_W-1:0] meta_r;
	logic [eeprom_host_pkg::SYNC_W-1:0] q_r;

	// First stage feeds only the second stage
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			meta_r <= '0;
			q_r    <= '0;
		end
		else if (clk_en)
		begin
			meta_r <= d;
			q_r    <= meta_r;
		end
	end

	assign q = q_r;

endmodule // pin_sync

/* File: rtl/eeprom_host.sv */
// Host-side controller driving a parallel byte-write EEPROM through its pins
`timescale 1ns/1ps
module eeprom_host #(
	parameter int POR_CYCLES     = eeprom_host_pkg::POR_CYC,
	parameter int WC_STD_CYCLES  = eeprom_host_pkg::WC_STD_CYC,
	parameter int WC_FAST_CYCLES = eeprom_host_pkg::WC_FAST_CYC,
	parameter int CLR_CYCLES     = eeprom_host_pkg::CLR_CYC
) (
	input  wire logic                                ref_clk,
	input  wire logic                                resetn,
	input  wire logic                                clk_en,
	input  wire logic                                fast_write,
	input  wire logic                                use_ready_busy,
	input  wire logic                                cmd_valid,
	output logic                                     cmd_ready,
	input  wire logic [1:0]                          cmd_op,
	input  wire logic                                cmd_id_area,
	input  wire logic [eeprom_host_pkg::ADDR_W-1:0] cmd_addr,
	input  wire logic [eeprom_host_pkg::DATA_W-1:0] cmd_wdata,
	output logic                                     resp_valid,
	output logic                                     resp_err,
	output logic      [eeprom_host_pkg::DATA_W-1:0] resp_rdata,
	output logic                                     chip_sel_n,
	output logic                                     out_gate_n,
	output logic                                     write_strobe_n,
	output logic                                     out_gate_hv,
	output logic                                     id_area_select_hv,
	output logic      [eeprom_host_pkg::ADDR_W-1:0] byte_address_lines,
	output logic      [eeprom_host_pkg::DATA_W-1:0] byte_data_lines_o,
	output logic                                     byte_data_lines_oe,
	input  wire logic [eeprom_host_pkg::DATA_W-1:0] byte_data_lines_i,
	input  wire logic                                ready_busy_i,
	input  wire logic                                supply_good
);

	// ***************************************************************
	// Pin synchronisers
	// ***************************************************************
	logic [eeprom_host_pkg::SYNC_W-1:0] sync_q;
	logic [eeprom_host_pkg::DATA_W-1:0] data_s;
	logic                               rdy_s;
	logic                               supply_s;

	pin_sync u_sync (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.clk_en  (clk_en),
		.d       ({supply_good, ready_busy_i, byte_data_lines_i}),
		.q       (sync_q)
	);

	// Supply sense and ready/busy are plain levels after the crossing
	assign data_s   = sync_q[7:0];
	assign rdy_s    = sync_q[8];
	assign supply_s = sync_q[9];

	// ***************************************************************
	// Sequencer state
	// ***************************************************************
	eeprom_host_pkg::state_t            state_r, state_nxt;
	logic [eeprom_host_pkg::PH_W-1:0]   ph_r, ph_nxt;
	logic [eeprom_host_pkg::LT_W-1:0]   lt_r, lt_nxt;
	logic [eeprom_host_pkg::ADDR_W-1:0] addr_r, addr_nxt;
	logic [eeprom_host_pkg::DATA_W-1:0] wdata_r, wdata_nxt;
	logic [eeprom_host_pkg::DATA_W-1:0] rdata_r, rdata_nxt;
	logic                               ce_n_r, ce_n_nxt;
	logic                               oe_n_r, oe_n_nxt;
	logic                               we_n_r, we_n_nxt;
	logic                               dq_oe_r, dq_oe_nxt;
	logic                               hv_oe_r, hv_oe_nxt;
	logic                               hv_a9_r, hv_a9_nxt;
	logic                               resp_valid_r, resp_valid_nxt;
	logic                               resp_err_r, resp_err_nxt;
	logic                               fin;
	logic                               fin_err;
	logic [eeprom_host_pkg::LT_W-1:0]   wc_limit;
	logic                               poll_match;
	logic                               rdy_done;

	// Timeout follows the fitted part speed; passing it means a dead device
	assign wc_limit   = fast_write ? eeprom_host_pkg::LT_W'(WC_FAST_CYCLES) // RL9
	                               : eeprom_host_pkg::LT_W'(WC_STD_CYCLES);
	// A poll read matches only when bit 7 reads back true, never on the inverted value
	assign poll_match = (data_s[7] == wdata_r[7]); // RL13
	// Ready/busy is ignored until the device has had time to go busy
	assign rdy_done   = use_ready_busy && rdy_s // RL11 RL12
	                    && (lt_r >= eeprom_host_pkg::LT_W'(eeprom_host_pkg::DB_CYC));
	assign cmd_ready  = (state_r == eeprom_host_pkg::ST_IDLE) && supply_s; // RL15 RL16

	// Next-state logic for the whole pin sequencer
	always_comb
	begin
		state_nxt      = state_r;
		ph_nxt         = ph_r + 1'b1;
		lt_nxt         = lt_r;
		addr_nxt       = addr_r;
		wdata_nxt      = wdata_r;
		rdata_nxt      = rdata_r;
		ce_n_nxt       = ce_n_r;
		oe_n_nxt       = oe_n_r;
		we_n_nxt       = we_n_r;
		dq_oe_nxt      = dq_oe_r;
		hv_oe_nxt      = hv_oe_r;
		hv_a9_nxt      = hv_a9_r;
		resp_valid_nxt = 1'b0;
		resp_err_nxt   = resp_err_r;
		fin            = 1'b0;
		fin_err        = 1'b0;
		case (state_r)
			eeprom_host_pkg::ST_PWR:
			begin
				// Hold off all access until the power-on lockout has expired
				if (!supply_s)
					lt_nxt = '0; // RL16
				else if (lt_r >= eeprom_host_pkg::LT_W'(POR_CYCLES - 1))
				begin
					state_nxt = eeprom_host_pkg::ST_IDLE; // RL17
					lt_nxt    = '0;
				end
				else
					lt_nxt = lt_r + 1'b1;
			end
			eeprom_host_pkg::ST_IDLE:
			begin
				ph_nxt = '0;
				lt_nxt = '0;
				if (!supply_s)
					state_nxt = eeprom_host_pkg::ST_PWR; // RL16
				else if (cmd_valid)
				begin
					// Id area sits at the top 32 addresses with 12 V on the id select line
					addr_nxt     = cmd_id_area ? {eeprom_host_pkg::ID_HIGH,
					               cmd_addr[eeprom_host_pkg::ID_LOW_W-1:0]} : cmd_addr; // RL20
					hv_a9_nxt    = cmd_id_area; // RL20 RL21
					wdata_nxt    = cmd_wdata;
					resp_err_nxt = 1'b0;
					ce_n_nxt     = 1'b0;
					case (cmd_op)
						eeprom_host_pkg::OP_READ:
						begin
							oe_n_nxt  = 1'b0; // RL2
							state_nxt = eeprom_host_pkg::ST_RD;
						end
						eeprom_host_pkg::OP_WRITE:
						begin
							dq_oe_nxt = 1'b1;
							state_nxt = eeprom_host_pkg::ST_WR_SET;
						end
						eeprom_host_pkg::OP_CLEAR:
						begin
							hv_oe_nxt = 1'b1; // RL19 RL21
							hv_a9_nxt = 1'b0;
							addr_nxt  = '0;
							state_nxt = eeprom_host_pkg::ST_CLR_SET;
						end
						default:
						begin
							ce_n_nxt = 1'b1;
							fin      = 1'b1;
							fin_err  = 1'b1;
						end
					endcase
				end
			end
			eeprom_host_pkg::ST_RD:
			begin
				// Sample only after access time plus the synchroniser delay
				if (ph_r == eeprom_host_pkg::PH_W'(eeprom_host_pkg::ACC_CYC - 1))
				begin
					rdata_nxt = data_s; // RL2
					fin       = 1'b1;
				end
			end
			eeprom_host_pkg::ST_WR_SET:
			begin
				// Address settles before the strobe falls and latches it
				if (ph_r == eeprom_host_pkg::PH_W'(eeprom_host_pkg::AS_CYC - 1))
				begin
					we_n_nxt  = 1'b0; // RL4 RL5
					ph_nxt    = '0;
					state_nxt = eeprom_host_pkg::ST_WR_PULSE;
				end
			end
			eeprom_host_pkg::ST_WR_PULSE:
			begin
				lt_nxt = lt_r + 1'b1;
				if (ph_r == eeprom_host_pkg::PH_W'(eeprom_host_pkg::WP_CYC - 1))
				begin
					we_n_nxt  = 1'b1; // RL6
					ph_nxt    = '0;
					state_nxt = eeprom_host_pkg::ST_WR_HOLD;
				end
			end
			eeprom_host_pkg::ST_WR_HOLD:
			begin
				lt_nxt = lt_r + 1'b1;
				if (ph_r == eeprom_host_pkg::PH_W'(eeprom_host_pkg::DH_CYC - 1))
				begin
					dq_oe_nxt = 1'b0; // RL7
					ce_n_nxt  = 1'b1;
					ph_nxt    = '0;
					state_nxt = eeprom_host_pkg::ST_POLL_GAP; // RL8
				end
			end
			eeprom_host_pkg::ST_POLL_GAP, eeprom_host_pkg::ST_POLL:
			begin
				// Repeated status reads until bit 7 is true, ready rises or time runs out
				lt_nxt = lt_r + 1'b1;
				if (rdy_done)
					fin = 1'b1; // RL11
				else if (lt_r >= wc_limit)
				begin
					fin     = 1'b1; // RL9
					fin_err = 1'b1;
				end
				else if (state_r == eeprom_host_pkg::ST_POLL_GAP)
				begin
					if (ph_r == eeprom_host_pkg::PH_W'(eeprom_host_pkg::GAP_CYC - 1))
					begin
						ce_n_nxt  = 1'b0; // RL10
						oe_n_nxt  = 1'b0;
						ph_nxt    = '0;
						state_nxt = eeprom_host_pkg::ST_POLL;
					end
				end
				else if (ph_r == eeprom_host_pkg::PH_W'(eeprom_host_pkg::ACC_CYC - 1))
				begin
					ph_nxt = '0;
					if (poll_match)
					begin
						rdata_nxt = data_s; // RL14
						fin       = 1'b1;
					end
					else
					begin
						ce_n_nxt  = 1'b1; // RL13
						oe_n_nxt  = 1'b1;
						state_nxt = eeprom_host_pkg::ST_POLL_GAP;
					end
				end
			end
			eeprom_host_pkg::ST_CLR_SET:
			begin
				if (ph_r == eeprom_host_pkg::PH_W'(eeprom_host_pkg::CLR_SH_CYC - 1))
				begin
					we_n_nxt  = 1'b0; // RL19
					lt_nxt    = '0;
					state_nxt = eeprom_host_pkg::ST_CLR_PULSE;
				end
			end
			eeprom_host_pkg::ST_CLR_PULSE:
			begin
				lt_nxt = lt_r + 1'b1;
				ph_nxt = '0;
				if (lt_r >= eeprom_host_pkg::LT_W'(CLR_CYCLES - 1))
				begin
					we_n_nxt  = 1'b1; // RL19
					state_nxt = eeprom_host_pkg::ST_CLR_HOLD;
				end
			end
			eeprom_host_pkg::ST_CLR_HOLD:
			begin
				if (ph_r == eeprom_host_pkg::PH_W'(eeprom_host_pkg::CLR_SH_CYC - 1))
					fin = 1'b1;
			end
			default:
				state_nxt = eeprom_host_pkg::ST_PWR;
		endcase
		// Common completion: release every pin and pulse the answer
		if (fin)
		begin
			state_nxt      = eeprom_host_pkg::ST_IDLE;
			ce_n_nxt       = 1'b1;
			oe_n_nxt       = 1'b1;
			we_n_nxt       = 1'b1;
			dq_oe_nxt      = 1'b0;
			hv_oe_nxt      = 1'b0;
			hv_a9_nxt      = 1'b0;
			resp_valid_nxt = 1'b1;
			resp_err_nxt   = fin_err;
		end
	end

	// Registers of the sequencer; select, gate and strobe idle high, the other pins low and released in reset
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_r      <= eeprom_host_pkg::ST_PWR;
			ph_r         <= '0;
			lt_r         <= '0;
			addr_r       <= '0;
			wdata_r      <= '0;
			rdata_r      <= '0;
			ce_n_r       <= 1'b1;
			oe_n_r       <= 1'b1;
			we_n_r       <= 1'b1;
			dq_oe_r      <= 1'b0;
			hv_oe_r      <= 1'b0;
			hv_a9_r      <= 1'b0;
			resp_valid_r <= 1'b0;
			resp_err_r   <= 1'b0;
		end
		else if (clk_en)
		begin
			state_r      <= state_nxt;
			ph_r         <= ph_nxt;
			lt_r         <= lt_nxt;
			addr_r       <= addr_nxt;
			wdata_r      <= wdata_nxt;
			rdata_r      <= rdata_nxt;
			ce_n_r       <= ce_n_nxt;
			oe_n_r       <= oe_n_nxt;
			we_n_r       <= we_n_nxt;
			dq_oe_r      <= dq_oe_nxt;
			hv_oe_r      <= hv_oe_nxt;
			hv_a9_r      <= hv_a9_nxt;
			resp_valid_r <= resp_valid_nxt;
			resp_err_r   <= resp_err_nxt;
		end
	end

	// Outputs straight from flip-flops
	assign chip_sel_n         = ce_n_r;
	assign out_gate_n         = oe_n_r;
	assign write_strobe_n     = we_n_r;
	assign out_gate_hv        = hv_oe_r;
	assign id_area_select_hv  = hv_a9_r;
	assign byte_address_lines = addr_r; // RL1
	assign byte_data_lines_o  = wdata_r;
	assign byte_data_lines_oe = dq_oe_r;
	assign resp_valid         = resp_valid_r;
	assign resp_err           = resp_err_r;
	assign resp_rdata         = rdata_r;

	// ***************************************************************
	// Assertions
	// ***************************************************************
	property p_strobe_legal;
		@(posedge ref_clk) disable iff (!resetn)
		!we_n_r |-> (!ce_n_r && oe_n_r);
	endproperty
	a_strobe_legal: assert property (p_strobe_legal) // RL18
		else $error("write strobe low with select high or gate low");

	property p_no_contention;
		@(posedge ref_clk) disable iff (!resetn)
		dq_oe_r |-> oe_n_r;
	endproperty
	a_no_contention: assert property (p_no_contention) // RL3
		else $error("host drives data while device may drive");

	property p_addr_stable;
		@(posedge ref_clk) disable iff (!resetn)
		(!we_n_r && $past(!we_n_r)) |-> $stable(addr_r);
	endproperty
	a_addr_stable: assert property (p_addr_stable) // RL5
		else $error("address moved during write pulse");

	property p_data_at_rise;
		@(posedge ref_clk) disable iff (!resetn)
		($rose(we_n_r) && !hv_oe_r) |-> (dq_oe_r && $stable(wdata_r)) ##1 dq_oe_r;
	endproperty
	a_data_at_rise: assert property (p_data_at_rise) // RL6
		else $error("data not held across strobe rising edge");

	property p_pulse_width;
		@(posedge ref_clk) disable iff (!resetn)
		($fell(we_n_r) && !hv_oe_r && clk_en) |-> (!we_n_r)[*8];
	endproperty
	a_pulse_width: assert property (p_pulse_width) // RL4
		else $error("write pulse too short");

	property p_por_lock;
		@(posedge ref_clk) disable iff (!resetn)
		$rose(supply_s) |-> (!cmd_ready)[*8];
	endproperty
	a_por_lock: assert property (p_por_lock) // RL17
		else $error("command accepted inside power-on lockout");

	property p_no_cmd_busy;
		@(posedge ref_clk) disable iff (!resetn)
		(state_r == eeprom_host_pkg::ST_POLL) |-> (!cmd_ready && !dq_oe_r && we_n_r);
	endproperty
	a_no_cmd_busy: assert property (p_no_cmd_busy) // RL15
		else $error("new access during write cycle");

	property p_clear_setup;
		@(posedge ref_clk) disable iff (!resetn)
		($fell(we_n_r) && hv_oe_r) |-> (!ce_n_r && oe_n_r) ##1 (!we_n_r && hv_oe_r)[*8];
	endproperty
	a_clear_setup: assert property (p_clear_setup) // RL19
		else $error("chip clear pulse malformed");

	property p_id_range;
		@(posedge ref_clk) disable iff (!resetn)
		(hv_a9_r && !ce_n_r) |-> (addr_r >= eeprom_host_pkg::ID_BASE);
	endproperty
	a_id_range: assert property (p_id_range) // RL20
		else $error("id area access outside id range");

endmodule // eeprom_host

/* File: testbench/eeprom_model.sv */
// Behavioural parallel byte-write EEPROM that answers the host controller's pins
`timescale 1ns/1ps
module eeprom_model #(
	parameter int STD_NS  = 800,
	parameter int FAST_NS = 500,
	parameter int SLOW_NS = 3000,
	parameter int POR_NS  = 150,
	parameter int CLR_NS  = 60
) (
	input  wire logic        chip_sel_n,
	input  wire logic        out_gate_n,
	input  wire logic        write_strobe_n,
	input  wire logic        out_gate_hv,
	input  wire logic        id_area_select_hv,
	input  wire logic [12:0] byte_address_lines,
	input  wire logic [7:0]  d,
	input  wire logic        supply_good,
	input  wire logic        fast_part,
	input  wire logic        slow_write,
	input  wire logic        rb_fitted,
	output logic      [7:0]  q,
	output logic             q_oe,
	output logic             rb_low
);
	// ***************************************************************
	// Storage and write latches
	// ***************************************************************
	logic [7:0]  mem [0:8191];
	logic [7:0]  idm [0:31];
	logic [12:0] lat_a;
	logic [7:0]  lat_d;
	logic [7:0]  last_q;
	logic [7:0]  rd_val;
	logic        busy;
	logic        locked;
	logic        lat_id;
	logic        armed;
	logic        sel_id;
	realtime     t_fall;

	// Known contents so reads and the clear have something to show
	initial
	begin
		for (int i = 0; i < 8192; i++) mem[i] = 8'(i) ^ 8'(i >> 8);
		for (int i = 0; i < 32; i++) idm[i] = 8'hA5 ^ 8'(i);
		busy   = 1'b0;
		locked = 1'b1;
		armed  = 1'b0;
		last_q = 8'h00;
	end

	// ***************************************************************
	// Read path
	// ***************************************************************
	assign sel_id = id_area_select_hv && (byte_address_lines >= 13'h1FE0);
	assign q_oe   = !chip_sel_n && !out_gate_n && write_strobe_n;
	// A busy read is a status poll: bit 7 inverted, the rest junk
	assign rd_val = busy ? ~lat_d : sel_id ? idm[byte_address_lines[4:0]]
		: mem[byte_address_lines];
	always @(rd_val or q_oe) if (q_oe) last_q = rd_val;
	// Released lines float away from the last value, never hold it
	assign q      = q_oe ? rd_val : ~last_q;
	assign rb_low = busy && rb_fitted;

	// ***************************************************************
	// Power sense and lockout
	// ***************************************************************
	always @(negedge supply_good) locked = 1'b1;
	always @(posedge supply_good)
	begin
		locked = 1'b1;
		#(POR_NS) locked = supply_good ? 1'b0 : 1'b1;
	end

	// ***************************************************************
	// Write strobe edges
	// ***************************************************************
	always @(negedge write_strobe_n)
	begin
		armed = 1'b0;
		if (!chip_sel_n && out_gate_hv) t_fall = $realtime;
		else if (!chip_sel_n && out_gate_n && !busy)
		begin
			lat_a = byte_address_lines;
			lat_id = sel_id;
			armed = 1'b1;
		end
	end
	always @(posedge write_strobe_n)
	begin
		if (!chip_sel_n && out_gate_hv && ($realtime - t_fall >= CLR_NS))
			for (int i = 0; i < 8192; i++) mem[i] = 8'hFF;
		else if (armed && !chip_sel_n && out_gate_n && supply_good && !locked)
		begin
			lat_d = d;
			busy = 1'b1;
			#(slow_write ? SLOW_NS : fast_part ? FAST_NS : STD_NS);
			if (lat_id) idm[lat_a[4:0]] = lat_d;
			else mem[lat_a] = lat_d;
			busy = 1'b0;
		end
		armed = 1'b0;
	end
endmodule // eeprom_model

/* File: testbench/tb_top.sv */
// Self-checking bench for the EEPROM host controller against a behavioural device
`timescale 1ns/1ps
module tb_top;
	typedef struct packed {logic err; logic chk; logic [7:0] data;} exp_t;
	logic        ref_clk, resetn, fast_write, use_ready_busy, cmd_valid, cmd_ready;
	logic        cmd_id_area, resp_valid, resp_err, chip_sel_n, out_gate_n, write_strobe_n;
	logic        out_gate_hv, id_area_select_hv, byte_data_lines_oe, supply_good;
	logic        slow_write, rb_fitted, q_oe, rb_low;
	logic [1:0]  cmd_op;
	logic [12:0] cmd_addr, byte_address_lines;
	logic [7:0]  cmd_wdata, resp_rdata, byte_data_lines_o, q, bus_w;
	exp_t        exp_q[$];
	exp_t        e;
	int          failures, n_checks;

	// The host wins the bus only when it enables; otherwise the device side
	assign bus_w = byte_data_lines_oe ? byte_data_lines_o : q;

	eeprom_host #(.POR_CYCLES(50), .WC_STD_CYCLES(400), .WC_FAST_CYCLES(300),
		.CLR_CYCLES(20)) dut_u (
		.ref_clk(ref_clk), .resetn(resetn), .clk_en(1'b1), .fast_write(fast_write),
		.use_ready_busy(use_ready_busy), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_op(cmd_op), .cmd_id_area(cmd_id_area), .cmd_addr(cmd_addr),
		.cmd_wdata(cmd_wdata), .resp_valid(resp_valid), .resp_err(resp_err),
		.resp_rdata(resp_rdata), .chip_sel_n(chip_sel_n), .out_gate_n(out_gate_n),
		.write_strobe_n(write_strobe_n), .out_gate_hv(out_gate_hv),
		.id_area_select_hv(id_area_select_hv), .byte_address_lines(byte_address_lines),
		.byte_data_lines_o(byte_data_lines_o), .byte_data_lines_oe(byte_data_lines_oe),
		.byte_data_lines_i(bus_w), .ready_busy_i(~rb_low), .supply_good(supply_good));

	eeprom_model dev_u (
		.chip_sel_n(chip_sel_n), .out_gate_n(out_gate_n), .write_strobe_n(write_strobe_n),
		.out_gate_hv(out_gate_hv), .id_area_select_hv(id_area_select_hv),
		.byte_address_lines(byte_address_lines), .d(bus_w), .supply_good(supply_good),
		.fast_part(fast_write), .slow_write(slow_write), .rb_fitted(rb_fitted),
		.q(q), .q_oe(q_oe), .rb_low(rb_low));

	// ***************************************************************
	// Compare, close and command tasks
	// ***************************************************************
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
		n_checks++;
		if (seen !== want)
		begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, want, seen);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// One command, held until taken, then waited on to its answer
	task automatic do_cmd(input logic [1:0] op, input logic id, input logic [12:0] a,
		input logic [7:0] wd, input logic err, input logic chk, input logic [7:0] want);
		int k;
		exp_q.push_back(exp_t'{err, chk, want});
		@(posedge ref_clk);
		#1;
		cmd_op = op;
		cmd_id_area = id;
		cmd_addr = a;
		cmd_wdata = wd;
		cmd_valid = 1'b1;
		for (k = 0; k < 300; k++)
		begin
			@(posedge ref_clk);
			if (cmd_ready === 1'b1) break;
		end
		check("taken", 8'(k < 300), 8'h01);
		#1 cmd_valid = 1'b0;
		for (k = 0; k < 4000; k++)
		begin
			@(posedge ref_clk);
			if (resp_valid === 1'b1) break;
		end
		check("answered", 8'(k < 4000), 8'h01);
		#1;
	endtask

	// ***************************************************************
	// Monitors
	// ***************************************************************
	// Oldest note is matched against each answer as it appears
	always @(posedge ref_clk)
	begin
		if (resp_valid === 1'b1)
		begin
			if (exp_q.size() == 0) check("spare answer", 8'h01, 8'h00);
			else
			begin
				e = exp_q.pop_front();
				check("resp_err", {7'h0, resp_err}, {7'h0, e.err});
				if (e.chk) check("resp_rdata", resp_rdata, e.data);
			end
		end
		check("bus fight", {7'h0, byte_data_lines_oe & q_oe}, 8'h00);
	end

	initial
	begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// Cuts a hang short well after the expected run length
	initial
	begin
		#160000;
		failures++;
		$display("watchdog expired");
		complete_run();
	end

	// ***************************************************************
	// Scenarios
	// ***************************************************************
	initial
	begin : main
		logic [12:0] a;
		logic [7:0]  d;
		resetn = 1'b0;
		supply_good = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = 2'h0;
		cmd_id_area = 1'b0;
		cmd_addr = 13'h0000;
		cmd_wdata = 8'h00;
		fast_write = 1'b0;
		use_ready_busy = 1'b1;
		rb_fitted = 1'b1;
		slow_write = 1'b0;
		void'($urandom(32'h7CE936A5));
		repeat (5) @(posedge ref_clk);
		#1 resetn = 1'b1;
		supply_good = 1'b1;
		for (int j = 0; j < 4; j++)
		begin
			a = 13'($urandom);
			do_cmd(eeprom_host_pkg::OP_READ, 1'b0, a, 8'h00, 1'b0, 1'b1,
				a[7:0] ^ {3'h0, a[12:8]});
		end
		$display("test reads done");
		// Ready/busy end, polling only, fast part: each write read back at once
		for (int j = 0; j < 3; j++)
		begin
			use_ready_busy = (j != 1);
			rb_fitted = (j != 1);
			fast_write = (j == 2);
			a = 13'($urandom % 13'h1FE0);
			d = 8'($urandom);
			do_cmd(eeprom_host_pkg::OP_WRITE, 1'b0, a, d, 1'b0, 1'b0, 8'h00);
			do_cmd(eeprom_host_pkg::OP_READ, 1'b0, a, 8'h00, 1'b0, 1'b1, d);
		end
		$display("test writes done");
		a = 13'h1FE0 + 13'($urandom % 32);
		d = 8'($urandom);
		do_cmd(eeprom_host_pkg::OP_WRITE, 1'b1, a, d, 1'b0, 1'b0, 8'h00);
		do_cmd(eeprom_host_pkg::OP_READ, 1'b1, a, 8'h00, 1'b0, 1'b1, d);
		do_cmd(eeprom_host_pkg::OP_READ, 1'b0, a, 8'h00, 1'b0, 1'b1,
			a[7:0] ^ {3'h0, a[12:8]});
		$display("test id area done");
		// Device slower than the host's limit: the write is reported failed
		fast_write = 1'b0;
		use_ready_busy = 1'b1;
		rb_fitted = 1'b1;
		slow_write = 1'b1;
		a = 13'($urandom % 13'h1FE0);
		d = 8'($urandom);
		do_cmd(eeprom_host_pkg::OP_WRITE, 1'b0, a, d, 1'b1, 1'b0, 8'h00);
		slow_write = 1'b0;
		repeat (1000) @(posedge ref_clk); // Let the device finish before touching it
		do_cmd(eeprom_host_pkg::OP_READ, 1'b0, a, 8'h00, 1'b0, 1'b1, d);
		do_cmd(2'h3, 1'b0, 13'h0000, 8'h00, 1'b1, 1'b0, 8'h00);
		$display("test timeout and illegal done");
		supply_good = 1'b0;
		repeat (4) @(posedge ref_clk);
		#1 check("ready in brownout", {7'h0, cmd_ready}, 8'h00);
		supply_good = 1'b1;
		a = 13'($urandom % 13'h1FE0);
		d = 8'($urandom);
		do_cmd(eeprom_host_pkg::OP_WRITE, 1'b0, a, d, 1'b0, 1'b0, 8'h00);
		do_cmd(eeprom_host_pkg::OP_READ, 1'b0, a, 8'h00, 1'b0, 1'b1, d);
		$display("test supply done");
		do_cmd(eeprom_host_pkg::OP_CLEAR, 1'b0, 13'h0000, 8'h00, 1'b0, 1'b0, 8'h00);
		for (int j = 0; j < 3; j++)
		begin
			a = 13'($urandom % 13'h1FE0);
			do_cmd(eeprom_host_pkg::OP_READ, 1'b0, a, 8'h00, 1'b0, 1'b1, 8'hFF);
		end
		$display("test chip clear done");
		complete_run();
	end
endmodule // tb_top
